// file: src/cpu_alu_dsp_datapath.sv
// Purpose: Integer unit, shared multiplier, divider and 40-bit accumulator engine.
// Assumes: Decoder presents one instruction at a time with operands already fetched.
// Notes: Divides hold o_ready low until the quotient and remainder are returned.
// Summary of operation
// RULE_01 - 16-bit integer add, subtract, shift, logic
// RULE_02 - Integer ops update carry, zero, negative, overflow, digit; only add and subtract set all five, logic and shift ops set zero and negative
// RULE_03 - Byte or word width; memory or register destination
// RULE_04 - All integer multiply forms share one multiplier
// RULE_05 - Signed/unsigned 32/16 and 16/16 division
// RULE_06 - Quotient to register zero, remainder register one
// RULE_07 - One cycle per divisor bit, fixed latency
// RULE_08 - Multiplier, barrel shifter, 40-bit adder, two accumulators
// RULE_09 - Engine and integer ops never overlap
// RULE_10 - Accumulator add, subtract, negate need no operand
// RULE_11 - Control register holds engine options
// RULE_12 - Engine operation set with optional write-back
// RULE_13 - Seventeenth multiplier bit zero or sign extended
// RULE_14 - Scaler gives 1.31 or integer, extended to 40
// RULE_15 - Fractional 16x16 multiply yields 1.31 product
// RULE_16 - Byte multiply 16-bit result, word 32-bit
// RULE_17 - Accumulator select; add and load shift operand
// RULE_18 - Adder: optional zero, complement plus borrow
// RULE_19 - Guard bits mismatch sets accumulator overflow flag
// RULE_20 - Saturation uses result, flags, enables, mode bit
// RULE_21 - Sticky saturation flags; combined OR flags
// RULE_22 - Overflow flags each pass; enabled overflow traps
// RULE_23 - Clamp to signed limit of selected width
`timescale 1ns/1ps
module cpu_alu_dsp_datapath import alu_dsp_pkg::*; (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_req_valid,
  input wire req_t i_req,
  output logic o_ready,
  output logic o_rsp_valid,
  output rsp_t o_rsp,
  output logic [15:0] o_status,
  output logic o_arith_trap
);
  logic [7:0] ctrl_ff;
  logic [1:0] trapen_ff;
  logic [15:0] status_ff, nxt_status;
  logic [39:0] acc_ff [2];
  logic ack_ff, ready_ff, rsp_valid_ff, trap_ff;
  logic [31:0] wb_dat_ff, rd_mux;
  rsp_t rsp_ff, nxt_rsp;
  div_state_t div_state_ff;
  logic [3:0] div_cnt_ff;
  logic [15:0] rem_ff, q_ff, dsr_ff;
  logic neg_q_ff, neg_r_ff;
  logic go, wb_hit, wb_wr, tgt;

  // RULE_09 one instruction
  assign go = i_req_valid & ready_ff;
  assign tgt = i_req.acc_b;
  assign wb_hit = i_wb_cyc & i_wb_stb & ~ack_ff;
  assign wb_wr = wb_hit & i_wb_we;
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = wb_dat_ff;
  assign o_ready = ready_ff;
  assign o_rsp_valid = rsp_valid_ff;
  assign o_rsp = rsp_ff;
  assign o_status = status_ff;
  assign o_arith_trap = trap_ff;

  // Integer unit
  logic [15:0] bb, int_res, zext_a, sext_a;
  logic [16:0] s16;
  logic [8:0] s8;
  logic [4:0] s4;
  logic is_sub, is_arith, int_op, int_msb, int_z, int_ovf;
  always_comb begin
    is_sub = (i_req.op == OP_SUB);
    is_arith = (i_req.op == OP_ADD) || is_sub;
    bb = is_sub ? ~i_req.b : i_req.b;
    // RULE_02 borrow form
    s16 = {1'b0, i_req.a} + {1'b0, bb} + {16'h0000, is_sub};
    s8 = {1'b0, i_req.a[7:0]} + {1'b0, bb[7:0]} + {8'h00, is_sub};
    s4 = {1'b0, i_req.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, is_sub};
    zext_a = i_req.byte_mode ? {8'h00, i_req.a[7:0]} : i_req.a;
    sext_a = i_req.byte_mode ? {{8{i_req.a[7]}}, i_req.a[7:0]} : i_req.a;
    int_op = 1'b1;
    // RULE_01 operation select
    case (i_req.op)
      OP_ADD, OP_SUB: int_res = s16[15:0];
      OP_AND: int_res = i_req.a & i_req.b;
      OP_IOR: int_res = i_req.a | i_req.b;
      OP_XOR: int_res = i_req.a ^ i_req.b;
      OP_SHL: int_res = i_req.a << i_req.b[3:0];
      OP_LSR: int_res = zext_a >> i_req.b[3:0];
      OP_ASR: int_res = $unsigned($signed(sext_a) >>> i_req.b[3:0]);
      default: begin
        int_res = 16'h0000;
        int_op = 1'b0;
      end
    endcase
    // RULE_03 byte ops keep upper byte
    if (i_req.byte_mode) begin
      int_res = {i_req.a[15:8], int_res[7:0]};
    end
    int_msb = i_req.byte_mode ? int_res[7] : int_res[15];
    int_z = i_req.byte_mode ? ~|int_res[7:0] : ~|int_res;
    int_ovf = i_req.byte_mode ? (i_req.a[7] == bb[7]) && (int_msb != i_req.a[7])
                              : (i_req.a[15] == bb[15]) && (int_msb != i_req.a[15]);
  end

  // Shared 17x17 multiplier
  logic signed [16:0] mx, my;
  logic signed [33:0] prod;
  logic [15:0] diff, x, y;
  logic dsp_s, sq;
  logic [32:0] p33;
  logic [39:0] p40;
  always_comb begin
    diff = i_req.a - i_req.b;
    sq = (i_req.op == OP_SQDIFF) || (i_req.op == OP_SQDIFF_ACC) || (i_req.op == OP_SQACC)
         || (i_req.op == OP_SQUARE);
    // RULE_09 difference feeds the square
    x = ((i_req.op == OP_SQDIFF) || (i_req.op == OP_SQDIFF_ACC)) ? diff : i_req.a;
    y = sq ? x : i_req.b;
    dsp_s = ~ctrl_ff[CTRL_UNSIGNED];
    // RULE_13 seventeenth bit
    mx = {dsp_s & x[15], x};
    my = {dsp_s & y[15], y};
    // RULE_04 integer multiply forms
    if (i_req.op == OP_IMUL) begin
      mx = {i_req.a_signed & i_req.a[15], i_req.a};
      my = {i_req.b_signed & i_req.b[15], i_req.b};
      if (i_req.byte_mode) begin
        mx = {9'h000, i_req.a[7:0]};
        my = {9'h000, i_req.b[7:0]};
      end else if (i_req.lit_mode) begin
        my = {12'h000, i_req.b[4:0]};
      end
    end
  end
  assign prod = mx * my;
  // RULE_15 fractional scaling
  assign p33 = ctrl_ff[CTRL_INT] ? prod[32:0] : {prod[31:0], 1'b0};
  // RULE_14 extend to 40
  assign p40 = {{7{p33[32]}}, p33};

  // Accumulator adder
  logic [39:0] bsh_in, bsh, src, opd, opx, sum, acc_new;
  logic use_zero, do_sub, pass, sx, sy, ov39, gov, b31, tsign, sat_en, sat_do;
  always_comb begin
    // RULE_17 barrel shift, positive is right
    bsh_in = {{8{i_req.a[15]}}, i_req.a, 16'h0000};
    bsh = i_req.shift[3] ? bsh_in << (~i_req.shift + 4'h1)
                         : $unsigned($signed(bsh_in) >>> i_req.shift);
    pass = 1'b1;
    use_zero = 1'b0;
    do_sub = 1'b0;
    opd = p40;
    // RULE_12 engine operations
    case (i_req.op)
      OP_CLR: begin
        use_zero = 1'b1;
        opd = 40'h0000000000;
      end
      OP_MULACC, OP_SQACC, OP_SQDIFF_ACC: opd = p40;
      OP_MULSUB: do_sub = 1'b1;
      OP_PROD, OP_SQUARE, OP_SQDIFF: use_zero = 1'b1;
      OP_NMUL: begin
        use_zero = 1'b1;
        do_sub = 1'b1;
      end
      // RULE_10 accumulator-only ops
      OP_AADD: opd = acc_ff[~tgt];
      OP_ASUB: begin
        opd = acc_ff[~tgt];
        do_sub = 1'b1;
      end
      OP_ANEG: begin
        opd = acc_ff[tgt];
        use_zero = 1'b1;
        do_sub = 1'b1;
      end
      OP_LOAD_ACC: begin
        opd = bsh;
        use_zero = 1'b1;
      end
      OP_ADDSH: opd = bsh;
      default: pass = 1'b0;
    endcase
    // RULE_18 zero input, complement and borrow
    src = use_zero ? 40'h0000000000 : acc_ff[tgt];
    opx = do_sub ? ~opd : opd;
    sum = src + opx + {39'h0000000000, do_sub};
    sx = src[39];
    sy = opx[39];
    // RULE_19 guard and sign overflow
    ov39 = (sx == sy) && (sum[39] != sx);
    gov = !((&sum[39:32]) || (~|sum[39:32]));
    b31 = !((&sum[39:31]) || (~|sum[39:31])) || ov39;
    tsign = ov39 ? sx : sum[39];
    // RULE_20 saturation decision
    sat_en = tgt ? ctrl_ff[CTRL_SAT_B] : ctrl_ff[CTRL_SAT_A];
    sat_do = sat_en && (ctrl_ff[CTRL_SAT_MODE] ? ov39 : b31);
    acc_new = sum;
    // RULE_23 clamp value
    if (sat_do) begin
      if (ctrl_ff[CTRL_SAT_MODE]) begin
        acc_new = tsign ? SAT_NEG39 : SAT_POS39;
      end else begin
        acc_new = tsign ? SAT_NEG31 : SAT_POS31;
      end
    end
  end

  // RULE_08 two accumulators
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_ff[0] <= 40'h0000000000;
      acc_ff[1] <= 40'h0000000000;
    end else if (go && pass) begin
      acc_ff[tgt] <= acc_new;
    end
  end

  // Write-back of the other accumulator, rounded and optionally saturated
  logic [39:0] wacc;
  logic [15:0] wb_word;
  logic round_inc, wb_op;
  always_comb begin
    wacc = acc_ff[~tgt];
    round_inc = (ctrl_ff[CTRL_CONV_ROUND] || wacc[15:0] != ROUND_TIE) ? wacc[15] : wacc[16];
    wb_word = wacc[31:16] + {15'h0000, round_inc};
    if (ctrl_ff[CTRL_SAT_MEM] && !((&wacc[39:31]) || (~|wacc[39:31]))) begin
      wb_word = wacc[39] ? 16'h8000 : 16'h7FFF;
    end
    wb_op = (i_req.op == OP_CLR) || (i_req.op == OP_MULACC) || (i_req.op == OP_ACC_STORE)
            || (i_req.op == OP_MULSUB);
  end

  // Divider operand preparation
  logic [31:0] dvd, mag_n;
  logic [15:0] mag_d;
  logic [16:0] dtry;
  logic neg_n, neg_d, dge;
  always_comb begin
    // RULE_05 dividend forms
    dvd = i_req.div_long ? {i_req.hi, i_req.a}
                         : {{16{i_req.a_signed & i_req.a[15]}}, i_req.a};
    neg_n = i_req.a_signed & dvd[31];
    neg_d = i_req.a_signed & i_req.b[15];
    mag_n = neg_n ? (~dvd + 32'h00000001) : dvd;
    mag_d = neg_d ? (~i_req.b + 16'h0001) : i_req.b;
    dtry = {rem_ff, q_ff[15]};
    dge = dtry >= {1'b0, dsr_ff};
  end

  // RULE_07 one step per divisor bit
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_state_ff <= DIV_IDLE;
      div_cnt_ff <= 4'h0;
      rem_ff <= 16'h0000;
      q_ff <= 16'h0000;
      dsr_ff <= 16'h0000;
      neg_q_ff <= 1'b0;
      neg_r_ff <= 1'b0;
      ready_ff <= 1'b1;
    end else begin
      case (div_state_ff)
        DIV_IDLE: begin
          if (go && i_req.op == OP_DIV) begin
            div_state_ff <= DIV_RUN;
            div_cnt_ff <= 4'h0;
            rem_ff <= mag_n[31:16];
            q_ff <= mag_n[15:0];
            dsr_ff <= mag_d;
            neg_q_ff <= neg_n ^ neg_d;
            neg_r_ff <= neg_n;
            ready_ff <= 1'b0;
          end
        end
        DIV_RUN: begin
          rem_ff <= dge ? 16'(dtry - {1'b0, dsr_ff}) : dtry[15:0];
          q_ff <= {q_ff[14:0], dge};
          div_cnt_ff <= div_cnt_ff + 4'h1;
          if (div_cnt_ff == DIV_LAST) begin
            div_state_ff <= DIV_FIX;
          end
        end
        DIV_FIX: begin
          div_state_ff <= DIV_IDLE;
          ready_ff <= 1'b1;
        end
        default: div_state_ff <= DIV_IDLE;
      endcase
    end
  end

  // Response assembly
  always_comb begin
    nxt_rsp = '0;
    nxt_rsp.to_mem = i_req.to_mem;
    if (div_state_ff == DIV_FIX) begin
      // RULE_06 quotient low, remainder high
      nxt_rsp.to_mem = 1'b0;
      nxt_rsp.lo = neg_q_ff ? (~q_ff + 16'h0001) : q_ff;
      nxt_rsp.hi = neg_r_ff ? (~rem_ff + 16'h0001) : rem_ff;
      nxt_rsp.wide = 1'b1;
      nxt_rsp.div_done = 1'b1;
    end else if (int_op) begin
      nxt_rsp.lo = int_res;
    end else if (i_req.op == OP_IMUL) begin
      // RULE_16 result width
      nxt_rsp.lo = prod[15:0];
      nxt_rsp.hi = i_req.byte_mode ? 16'h0000 : prod[31:16];
      nxt_rsp.wide = ~i_req.byte_mode;
    end else if (wb_op && i_req.awb) begin
      nxt_rsp.lo = wb_word;
      nxt_rsp.acc_wb = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end else begin
      rsp_valid_ff <= (div_state_ff == DIV_FIX) || (go && i_req.op != OP_DIV);
      if ((div_state_ff == DIV_FIX) || (go && i_req.op != OP_DIV)) begin
        rsp_ff <= nxt_rsp;
      end
    end
  end

  // Status flags
  always_comb begin
    nxt_status = status_ff;
    if (go && int_op) begin
      nxt_status[ST_Z] = int_z;
      nxt_status[ST_N] = int_msb;
      if (is_arith) begin
        nxt_status[ST_C] = i_req.byte_mode ? s8[8] : s16[16];
        nxt_status[ST_DIGIT] = i_req.byte_mode ? s4[4] : s8[8];
        nxt_status[ST_OVF] = int_ovf;
      end
    end
    // Software clears sticky saturation with a one; a new event still wins
    if (wb_wr && i_wb_adr == OFS_STATUS && i_wb_sel[1]) begin
      nxt_status[ST_SAT_A] = status_ff[ST_SAT_A] & ~i_wb_dat[ST_SAT_A];
      nxt_status[ST_SAT_B] = status_ff[ST_SAT_B] & ~i_wb_dat[ST_SAT_B];
    end
    if (go && pass) begin
      // RULE_22 overflow updated each pass
      nxt_status[ST_GUARD_A + int'(tgt)] = gov;
      // RULE_21 sticky saturation
      if (sat_do) begin
        nxt_status[ST_SAT_A + int'(tgt)] = 1'b1;
      end
    end
    nxt_status[ST_GUARD_ANY] = nxt_status[ST_GUARD_A] | nxt_status[ST_GUARD_B];
    nxt_status[ST_SAT_ANY] = nxt_status[ST_SAT_A] | nxt_status[ST_SAT_B];
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // RULE_22 trap request
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      trap_ff <= 1'b0;
    end else begin
      trap_ff <= (status_ff[ST_GUARD_A] & trapen_ff[0]) | (status_ff[ST_GUARD_B] & trapen_ff[1]);
    end
  end

  // RULE_11 control and trap enables
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_ff <= CTRL_RST;
      trapen_ff <= TRAPEN_RST;
    end else if (wb_wr && i_wb_sel[0]) begin
      if (i_wb_adr == OFS_CTRL) begin
        ctrl_ff <= i_wb_dat[7:0];
      end
      if (i_wb_adr == OFS_TRAPEN) begin
        trapen_ff <= i_wb_dat[1:0];
      end
    end
  end

  // Register bus; unmapped reads return zero and are still acknowledged
  always_comb begin
    case (i_wb_adr)
      OFS_CTRL: rd_mux = {24'h000000, ctrl_ff};
      OFS_STATUS: rd_mux = {16'h0000, status_ff};
      OFS_TRAPEN: rd_mux = {30'h00000000, trapen_ff};
      OFS_ACCA_LO: rd_mux = acc_ff[0][31:0];
      OFS_ACCA_HI: rd_mux = {24'h000000, acc_ff[0][39:32]};
      OFS_ACCB_LO: rd_mux = acc_ff[1][31:0];
      OFS_ACCB_HI: rd_mux = {24'h000000, acc_ff[1][39:32]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_ff <= 1'b0;
      wb_dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= wb_hit;
      if (wb_hit && !i_wb_we) begin
        wb_dat_ff <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_div_latency: assert property (go && i_req.op == OP_DIV |-> ##18 (o_rsp_valid && o_rsp.div_done)) // RULE_07
    else $error("divide answer not after 18 cycles");
  a_div_busy: assert property (go && i_req.op == OP_DIV |=> !o_ready [*8]) // RULE_09
    else $error("ready during divide");
  a_div_quot: assert property (go && i_req.op == OP_DIV && !i_req.a_signed && !i_req.div_long
      && i_req.b != 16'h0000 |-> ##18 (o_rsp.lo == $past(i_req.a, 18) / $past(i_req.b, 18)
      && o_rsp.hi == $past(i_req.a, 18) % $past(i_req.b, 18))) // RULE_06
    else $error("wrong quotient or remainder");
  a_add_word: assert property (go && i_req.op == OP_ADD && !i_req.byte_mode |=> o_rsp_valid
      && o_rsp.lo == 16'($past(i_req.a) + $past(i_req.b))) // RULE_01
    else $error("wrong word sum");
  a_sub_borrow: assert property (go && is_sub && !i_req.byte_mode |=>
      o_status[ST_C] == ($past(i_req.a) >= $past(i_req.b))) // RULE_02
    else $error("borrow flag wrong");
  a_byte_upper: assert property (go && int_op && i_req.byte_mode |=>
      o_rsp.lo[15:8] == $past(i_req.a[15:8])) // RULE_03
    else $error("byte op changed upper byte");
  a_imul_word: assert property (go && i_req.op == OP_IMUL && !i_req.byte_mode && !i_req.lit_mode
      && !i_req.a_signed && !i_req.b_signed |=> {o_rsp.hi, o_rsp.lo} ==
      32'($past(i_req.a) * $past(i_req.b))) // RULE_16
    else $error("unsigned word product wrong");
  a_guard_flag: assert property (go && pass && !tgt && !sat_en |=> o_status[ST_GUARD_A] ==
      !((&acc_ff[0][39:32]) || (~|acc_ff[0][39:32]))) // RULE_19
    else $error("guard overflow flag wrong");
  a_sat_clamp: assert property (go && pass && !tgt && ctrl_ff[CTRL_SAT_A]
      && !ctrl_ff[CTRL_SAT_MODE] |=> ((&acc_ff[0][39:31]) || (~|acc_ff[0][39:31]))) // RULE_23
    else $error("saturated accumulator out of range");
  a_sat_sticky: assert property (o_status[ST_SAT_A] && !wb_wr |=> o_status[ST_SAT_A]) // RULE_21
    else $error("saturation flag lost");
  a_trap_raise: assert property (o_status[ST_GUARD_A] && trapen_ff[0] |=> o_arith_trap) // RULE_22
    else $error("trap not raised");
  c_div_done: cover property (go && i_req.op == OP_DIV ##18 o_rsp_valid);
  c_sat_a: cover property (go && pass && sat_do && !tgt);
  c_trap: cover property ($rose(o_arith_trap));
  c_acc_wb: cover property (o_rsp_valid && o_rsp.acc_wb);
endmodule : cpu_alu_dsp_datapath

// file: src/alu_dsp_pkg.sv
// Purpose: Shared constants and types of the core arithmetic datapath.
// Assumes: 32-bit classic Wishbone register port, byte addresses.
// Notes: Status and control bit positions are shared with the decoder.
package alu_dsp_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TRAPEN = 8'h08;
  localparam logic [7:0] OFS_ACCA_LO = 8'h0C;
  localparam logic [7:0] OFS_ACCA_HI = 8'h10;
  localparam logic [7:0] OFS_ACCB_LO = 8'h14;
  localparam logic [7:0] OFS_ACCB_HI = 8'h18;
  // core_control_reg fields
  localparam int CTRL_INT = 0;
  localparam int CTRL_CONV_ROUND = 1;
  localparam int CTRL_UNSIGNED = 2;
  localparam int CTRL_SAT_MODE = 4;
  localparam int CTRL_SAT_MEM = 5;
  localparam int CTRL_SAT_B = 6;
  localparam int CTRL_SAT_A = 7;
  localparam logic [7:0] CTRL_RST = 8'h20;
  localparam logic [1:0] TRAPEN_RST = 2'h0;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // core_status_reg fields; guard and saturation bits are indexed by accumulator
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_N = 2;
  localparam int ST_OVF = 3;
  localparam int ST_DIGIT = 4;
  localparam int ST_GUARD_A = 8;
  localparam int ST_GUARD_B = 9;
  localparam int ST_SAT_A = 10;
  localparam int ST_SAT_B = 11;
  localparam int ST_GUARD_ANY = 12;
  localparam int ST_SAT_ANY = 13;
  localparam logic [3:0] DIV_LAST = 4'hF;
  localparam logic [39:0] SAT_POS31 = 40'h007FFFFFFF;
  localparam logic [39:0] SAT_NEG31 = 40'hFF80000000;
  localparam logic [39:0] SAT_POS39 = 40'h7FFFFFFFFF;
  localparam logic [39:0] SAT_NEG39 = 40'h8000000000;
  localparam logic [15:0] ROUND_TIE = 16'h8000;
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_SHL, OP_LSR, OP_ASR,
    OP_IMUL, OP_DIV, OP_CLR, OP_SQDIFF, OP_SQDIFF_ACC, OP_MULACC, OP_SQACC, OP_ACC_STORE,
    OP_PROD, OP_SQUARE, OP_NMUL, OP_MULSUB, OP_AADD, OP_ASUB, OP_ANEG, OP_LOAD_ACC,
    OP_ADDSH
  } op_t;
  typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_FIX} div_state_t;
  typedef struct packed {
    op_t op;
    logic byte_mode;
    logic to_mem;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] hi;
    logic a_signed;
    logic b_signed;
    logic lit_mode;
    logic div_long;
    logic acc_b;
    logic awb;
    logic [3:0] shift;
  } req_t;
  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
    logic wide;
    logic to_mem;
    logic div_done;
    logic acc_wb;
  } rsp_t;
endpackage : alu_dsp_pkg

// file: tb/dec_model.sv
// Purpose: Decoder stand-in that presents one instruction at a time.
// Assumes: A request is taken on the edge where ready is sampled high.
// Notes: A released request bus shows inverted data, so stale operands never pass.
`timescale 1ns/1ps
module dec_model import alu_dsp_pkg::*; (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output req_t o_req
);
  initial begin
    o_valid = 1'b0;
    o_req = '0;
  end
  task automatic issue(input req_t r);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_req <= r;
    do @(posedge i_clk); while (i_ready !== 1'b1);
    o_valid <= 1'b0;
    o_req <= req_t'(~r);
  endtask : issue
endmodule : dec_model

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the arithmetic datapath.
// Assumes: Register port acks one cycle after the request is taken.
// Notes: Accumulator values are read back over the register port.
`timescale 1ns/1ps
module tb_top import alu_dsp_pkg::*; ;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat, rd;
  logic ack, req_valid, ready, rsp_valid, trap;
  req_t req, r;
  rsp_t rsp;
  logic [15:0] status;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  always #10 i_clk = ~i_clk;
  cpu_alu_dsp_datapath u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_req_valid(req_valid), .i_req(req), .o_ready(ready),
    .o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_status(status), .o_arith_trap(trap));
  dec_model u_dec (.i_clk(i_clk), .i_ready(ready), .o_valid(req_valid), .o_req(req));
  task automatic summarize();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge i_clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  function automatic req_t mk(op_t op, logic [15:0] a, logic [15:0] b);
    req_t q;
    q = '0;
    q.op = op;
    q.a = a;
    q.b = b;
    return q;
  endfunction : mk
  task automatic run(input req_t q, input int lat);
    int n;
    n = 0;
    u_dec.issue(q);
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    chk("latency", 40'(n), 40'(lat));
  endtask : run
  task automatic acc(input logic [7:0] lo, input logic [39:0] exp);
    wb(1'b0, lo, 32'h0, 4'hF);
    chk("acc_lo", 40'(rd), {8'h00, exp[31:0]});
    wb(1'b0, lo + 8'h04, 32'h0, 4'hF);
    chk("acc_hi", 40'(rd[7:0]), 40'(exp[39:32]));
  endtask : acc
  always @(posedge i_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    wb(1'b0, OFS_CTRL, 32'h0, 4'hF);
    chk("ctrl_rst", 40'(rd), 40'(CTRL_RST));
    wb(1'b0, 8'h40, 32'h0, 4'hF);
    chk("unmapped", 40'(rd), 40'h0);
    run(mk(OP_ADD, 16'h7FFF, 16'h0001), 1);
    chk("add", 40'(rsp.lo), 40'h8000);
    chk("add_flags", 40'(status[4:0]), 40'h1C);
    run(mk(OP_SUB, 16'h0005, 16'h0005), 1);
    chk("sub_flags", 40'(status[4:0]), 40'h13);
    r = mk(OP_ADD, 16'h12FF, 16'h0001);
    r.byte_mode = 1'b1;
    run(r, 1);
    chk("add_byte", 40'(rsp.lo), 40'h1200);
    chk("byte_flags", 40'(status[4:0]), 40'h13);
    r = mk(OP_IMUL, 16'hFFFF, 16'h0002);
    r.a_signed = 1'b1;
    r.b_signed = 1'b1;
    run(r, 1);
    chk("imul_ss", 40'({rsp.hi, rsp.lo}), 40'hFFFFFFFE);
    r.a_signed = 1'b0;
    r.b_signed = 1'b0;
    run(r, 1);
    chk("imul_uu", 40'({rsp.hi, rsp.lo}), 40'h0001FFFE);
    r.b = 16'hFFFF;
    r.a = 16'h0002;
    r.b_signed = 1'b1;
    run(r, 1);
    chk("imul_us", 40'({rsp.hi, rsp.lo}), 40'hFFFFFFFE);
    r = mk(OP_IMUL, 16'h0003, 16'hFFFF);
    r.lit_mode = 1'b1;
    run(r, 1);
    chk("imul_lit", 40'({rsp.hi, rsp.lo}), 40'h0000005D);
    r = mk(OP_IMUL, 16'h00FF, 16'h00FF);
    r.byte_mode = 1'b1;
    run(r, 1);
    chk("imul_byte", 40'(rsp.lo), 40'hFE01);
    chk("imul_narrow", 40'(rsp.wide), 40'h0);
    run(mk(OP_ASR, 16'h8000, 16'h0004), 1);
    chk("asr", 40'(rsp.lo), 40'hF800);
    run(mk(OP_DIV, 16'd100, 16'd7), 18);
    chk("div_u", 40'({rsp.hi, rsp.lo}), 40'h0002000E);
    chk("div_done", 40'({rsp.wide, rsp.div_done}), 40'h3);
    r = mk(OP_DIV, 16'hFF9C, 16'd7);
    r.hi = 16'hFFFF;
    r.a_signed = 1'b1;
    r.div_long = 1'b1;
    run(r, 18);
    chk("div_s32", 40'({rsp.hi, rsp.lo}), 40'hFFFEFFF2);
    wb(1'b1, OFS_CTRL, 32'h05, 4'h1);
    run(mk(OP_PROD, 16'hFFFF, 16'h0002), 1);
    acc(OFS_ACCA_LO, 40'h000001FFFE);
    wb(1'b1, OFS_CTRL, 32'h01, 4'h1);
    run(mk(OP_PROD, 16'hFFFF, 16'h0002), 1);
    acc(OFS_ACCA_LO, 40'hFFFFFFFFFE);
    wb(1'b1, OFS_CTRL, 32'h00, 4'h1);
    run(mk(OP_CLR, 16'h0, 16'h0), 1);
    repeat (3) run(mk(OP_MULACC, 16'h7FFF, 16'h7FFF), 1);
    acc(OFS_ACCA_LO, 40'h017FFA0006);
    chk("guard_any", 40'({status[12], status[8]}), 40'h3);
    wb(1'b1, OFS_TRAPEN, 32'h1, 4'h1);
    repeat (2) @(posedge i_clk);
    chk("trap_on", 40'(trap), 40'h1);
    wb(1'b1, OFS_TRAPEN, 32'h0, 4'h1);
    repeat (2) @(posedge i_clk);
    chk("trap_off", 40'(trap), 40'h0);
    run(mk(OP_ANEG, 16'h0, 16'h0), 1);
    acc(OFS_ACCA_LO, 40'hFE8005FFFA);
    wb(1'b1, OFS_CTRL, 32'h80, 4'h1);
    run(mk(OP_CLR, 16'h0, 16'h0), 1);
    repeat (2) run(mk(OP_MULACC, 16'h7FFF, 16'h7FFF), 1);
    acc(OFS_ACCA_LO, SAT_POS31);
    chk("sat_any", 40'({status[13], status[10]}), 40'h3);
    wb(1'b1, OFS_STATUS, 32'h400, 4'h2);
    chk("sat_clear", 40'(status[10]), 40'h0);
    r = mk(OP_PROD, 16'h4000, 16'h4000);
    r.acc_b = 1'b1;
    run(r, 1);
    acc(OFS_ACCB_LO, 40'h0020000000);
    acc(OFS_ACCA_LO, SAT_POS31);
    r = mk(OP_AADD, 16'h0, 16'h0);
    r.acc_b = 1'b1;
    run(r, 1);
    acc(OFS_ACCB_LO, 40'h009FFFFFFF);
    // Store-only move from B: rounded upper word, accumulator A untouched
    r = mk(OP_ACC_STORE, 16'h0, 16'h0);
    r.awb = 1'b1;
    run(r, 1);
    chk("store_word", 40'({rsp.acc_wb, rsp.lo}), 40'h1A000);
    acc(OFS_ACCA_LO, SAT_POS31);
    summarize();
  end
endmodule : tb_top
